// ==== stcs_peer.sv ====
/*
 * Remote serial peer for the transmit block: supplies the slave serial
 * clock and captures synchronous data on rising serial clock edges.
 * Assumes ref_clk is the block's clock and all pins are sampled on it.
 */
`timescale 1ns/1ps

module stcs_peer #(
    parameter int HALF = 8
) (
    input  wire logic       ref_clk,
    input  wire logic       run,
    input  wire logic       clear,
    input  wire logic       serial_data_o,
    input  wire logic       sclk_o,
    input  wire logic       sclk_oe,
    output logic            sclk_i,
    output logic [7:0]      cap,
    output logic [3:0]      nbits
);
    logic       line_q;
    logic [7:0] div_cnt;
    logic       line;

    initial begin
        sclk_i  = 1'b0;
        cap     = 8'h00;
        nbits   = 4'h0;
        line_q  = 1'b0;
        div_cnt = 8'h00;
    end

    // whoever drives the clock, the peer samples on its rising edge
    assign line = sclk_oe ? sclk_o : sclk_i;

    // slave clock stands low while run is low and toggles every HALF clocks while run is high
    always @(posedge ref_clk) begin
        if (!run) begin
            div_cnt <= 8'h00;
            sclk_i  <= 1'b0;
        end else if (div_cnt == 8'(HALF - 1)) begin
            div_cnt <= 8'h00;
            sclk_i  <= ~sclk_i;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    always @(posedge ref_clk) begin
        line_q <= line;
        if (clear) begin
            cap   <= 8'h00;
            nbits <= 4'h0;
        end else if (line && !line_q) begin
            cap   <= {serial_data_o, cap[7:1]};
            nbits <= nbits + 4'h1;
        end
    end
endmodule // stcs_peer

// ==== stcs_pkg.sv ====
/*
 * Constants for the serial transmit control/status block: register map,
 * control bit positions, reset values, frame and baud timing counts.
 * Assumes a single 10 MHz clock and a classic Wishbone register bus.
 */
package stcs_pkg;
    localparam logic [7:0]  ADR_CTRL    = 8'h00;
    localparam logic [7:0]  ADR_DATA    = 8'h04;
    localparam logic [7:0]  ADR_DIV     = 8'h08;
    localparam logic [7:0]  ADR_STAT    = 8'h0c;

    localparam int unsigned BIT_CLOCK_SOURCE_SELECT    = 7;
    localparam int unsigned BIT_NINE_EN = 6;
    localparam int unsigned BIT_TX_EN   = 5;
    localparam int unsigned BIT_MODE    = 4;
    localparam int unsigned BIT_BRK     = 3;
    localparam int unsigned BIT_SPEED   = 2;
    localparam int unsigned BIT_EMPTY   = 1;
    localparam int unsigned BIT_NINE_D  = 0;

    localparam logic [7:0]  CTRL_RST    = 8'h00;
    localparam logic [15:0] DIV_RST     = 16'h0004;

    localparam logic [4:0]  TICKS_HIGH  = 5'h04;
    localparam logic [4:0]  TICKS_LOW   = 5'h10;
    localparam logic [3:0]  LAST_BIT_8  = 4'h7;
    localparam logic [3:0]  LAST_BIT_9  = 4'h8;
    localparam logic [3:0]  LAST_BRK    = 4'hb;

    localparam int unsigned FIFO_WIDTH  = 9;
    localparam int unsigned FIFO_DEPTH  = 8;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_DATA  = 3'b010,
        ST_BRK   = 3'b011,
        ST_STOP  = 3'b100,
        ST_SYNC  = 3'b101
    } stcs_state_t;
endpackage

// ==== stcs_tx.sv ====
/*
 * Serial transmit block: Wishbone register slave, 8-word character FIFO,
 * async/sync transmit shifter and baud tick divider.
 * Assumes a classic Wishbone master on ref_clk and a peer on the serial pins.
 */
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/1ps

module stcs_fifo #(
    parameter int unsigned WIDTH = 9,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int unsigned PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic             push;
    logic             pop;

    assign in_ready  = (32'(level) != DEPTH);
    assign out_valid = (level != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                level <= level + 1'b1;
            end else if (pop && !push) begin
                level <= level - 1'b1;
            end
        end
    end
endmodule // stcs_fifo

module stcs_tx (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             serial_data_o,
    input  wire logic        sclk_i,
    output logic             sclk_o,
    output logic             sclk_oe
);
    logic [7:0]              ctrl;
    logic [15:0]             divisor;
    logic [15:0]             baud_cnt;
    stcs_pkg::stcs_state_t   state;
    logic [8:0]              shreg;
    logic [3:0]              bit_idx;
    logic [4:0]              tick_cnt;
    logic                    frame_nine;
    logic                    frame_brk;
    logic [2:0]              sclk_sync;
    logic                    sclk_level;
    logic [8:0]              fifo_word;
    logic                    fifo_valid;
    logic                    fifo_in_ready;
    logic [3:0]              fifo_level;
    logic                    pop;
    logic                    acc;
    logic                    acc_ok;
    logic                    wr_ctrl;
    logic                    wr_data;
    logic                    wr_div;
    logic                    tick;
    logic                    bit_done;
    logic                    sync_adv;
    logic                    brk_done;
    logic [4:0]              ticks_per_bit;
    logic [3:0]              last_bit;
    logic                    tsr_empty;
    logic [7:0]              next_ctrl;

    wire clock_source_select = ctrl[stcs_pkg::BIT_CLOCK_SOURCE_SELECT];
    wire ninth_bit_enable    = ctrl[stcs_pkg::BIT_NINE_EN];
    wire transmitter_enable  = ctrl[stcs_pkg::BIT_TX_EN];
    wire mode_select         = ctrl[stcs_pkg::BIT_MODE];
    wire break_request       = ctrl[stcs_pkg::BIT_BRK];
    wire baud_speed_select   = ctrl[stcs_pkg::BIT_SPEED];
    wire ninth_data_bit      = ctrl[stcs_pkg::BIT_NINE_D];

    // a data write into a full fifo is held off by withholding ack
    assign acc     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_data = acc && wb_we_i && (wb_adr_i == stcs_pkg::ADR_DATA) && wb_sel_i[0];
    assign acc_ok  = acc && !(wr_data && !fifo_in_ready);
    assign wr_ctrl = acc_ok && wb_we_i && (wb_adr_i == stcs_pkg::ADR_CTRL) && wb_sel_i[0];
    assign wr_div  = acc_ok && wb_we_i && (wb_adr_i == stcs_pkg::ADR_DIV);
    assign tsr_empty = (state == stcs_pkg::ST_IDLE);

    stcs_fifo #(
        .WIDTH (stcs_pkg::FIFO_WIDTH),
        .DEPTH (stcs_pkg::FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .in_valid  (wr_data && fifo_in_ready),
        .in_ready  (fifo_in_ready),
        .in_data   ({ninth_data_bit, wb_dat_i[7:0]}),
        .out_valid (fifo_valid),
        .out_ready (pop),
        .out_data  (fifo_word),
        .level     (fifo_level)
    );

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= acc_ok;
            wb_dat_o <= '0;
            if (acc_ok && !wb_we_i) begin
                case (wb_adr_i)
                    stcs_pkg::ADR_CTRL: wb_dat_o[7:0] <= {ctrl[7:2], tsr_empty, ctrl[0]};
                    stcs_pkg::ADR_DIV:  wb_dat_o[15:0] <= divisor;
                    stcs_pkg::ADR_STAT: wb_dat_o[5:0] <= {!fifo_valid, !fifo_in_ready,
                                                          fifo_level};
                    default:            wb_dat_o <= '0;
                endcase
            end
        end
    end

    // a software set of the break bit wins over the hardware clear
    always_comb begin
        next_ctrl = ctrl;
        if (wr_ctrl) begin
            next_ctrl = wb_dat_i[7:0];
        end
        next_ctrl[stcs_pkg::BIT_EMPTY] = 1'b0;
        if (brk_done && !(wr_ctrl && wb_dat_i[stcs_pkg::BIT_BRK])) begin
            next_ctrl[stcs_pkg::BIT_BRK] = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl <= stcs_pkg::CTRL_RST;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            divisor <= stcs_pkg::DIV_RST;
        end else if (wr_div) begin
            if (wb_sel_i[0]) begin
                divisor[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                divisor[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // baud tick: one-cycle enable every divisor+1 clocks
    assign tick = (baud_cnt == 16'h0000);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            baud_cnt <= stcs_pkg::DIV_RST;
        end else if (tick) begin
            baud_cnt <= divisor;
        end else begin
            baud_cnt <= baud_cnt - 16'h0001;
        end
    end

    // a level counts once stages two and three agree, so a one-clock glitch never shifts a bit
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sclk_sync  <= 3'h0;
            sclk_level <= 1'b0;
        end else begin
            sclk_sync  <= {sclk_sync[1:0], sclk_i};
            sclk_level <= (sclk_sync[1] == sclk_sync[2]) ? sclk_sync[2] : sclk_level;
        end
    end

    assign ticks_per_bit = baud_speed_select ? stcs_pkg::TICKS_HIGH
                                             : stcs_pkg::TICKS_LOW;
    assign bit_done = !mode_select && tick && (tick_cnt == ticks_per_bit - 5'h01);
    assign last_bit = frame_nine ? stcs_pkg::LAST_BIT_9 : stcs_pkg::LAST_BIT_8;
    // master advances in the same cycle as its own falling clock, slave after the peer's
    assign sync_adv = clock_source_select ? (tick && sclk_o)
                    : (sclk_level && sclk_sync[2:1] == 2'b00);
    assign pop = (state == stcs_pkg::ST_IDLE) && transmitter_enable && fifo_valid;
    assign brk_done = (state == stcs_pkg::ST_STOP) && frame_brk && bit_done;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sclk_oe <= 1'b0;
        end else begin
            sclk_oe <= mode_select && clock_source_select;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || state == stcs_pkg::ST_IDLE || bit_done) begin
            tick_cnt <= 5'h00;
        end else if (tick) begin
            tick_cnt <= tick_cnt + 5'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state         <= stcs_pkg::ST_IDLE;
            shreg         <= 9'h000;
            bit_idx       <= 4'h0;
            frame_nine    <= 1'b0;
            frame_brk     <= 1'b0;
            serial_data_o <= 1'b1;
            sclk_o        <= 1'b0;
        end else if (!transmitter_enable) begin
            state         <= stcs_pkg::ST_IDLE;
            frame_brk     <= 1'b0;
            serial_data_o <= 1'b1;
            sclk_o        <= 1'b0;
        end else begin
            case (state)
                stcs_pkg::ST_IDLE: begin
                    if (pop) begin
                        shreg      <= fifo_word;
                        bit_idx    <= 4'h0;
                        frame_nine <= ninth_bit_enable;
                        if (mode_select) begin
                            state         <= stcs_pkg::ST_SYNC;
                            frame_brk     <= 1'b0;
                            serial_data_o <= fifo_word[0];
                            sclk_o        <= 1'b0;
                        end else begin
                            state         <= stcs_pkg::ST_START;
                            frame_brk     <= break_request;
                            serial_data_o <= 1'b0;
                        end
                    end
                end
                stcs_pkg::ST_START: begin
                    if (bit_done) begin
                        state         <= frame_brk ? stcs_pkg::ST_BRK : stcs_pkg::ST_DATA;
                        serial_data_o <= frame_brk ? 1'b0 : shreg[0];
                    end
                end
                stcs_pkg::ST_DATA: begin
                    if (bit_done) begin
                        if (bit_idx == last_bit) begin
                            state         <= stcs_pkg::ST_STOP;
                            serial_data_o <= 1'b1;
                        end else begin
                            bit_idx       <= bit_idx + 4'h1;
                            shreg         <= {1'b0, shreg[8:1]};
                            serial_data_o <= shreg[1];
                        end
                    end
                end
                stcs_pkg::ST_BRK: begin
                    if (bit_done) begin
                        if (bit_idx == stcs_pkg::LAST_BRK) begin
                            state         <= stcs_pkg::ST_STOP;
                            serial_data_o <= 1'b1;
                        end else begin
                            bit_idx <= bit_idx + 4'h1;
                        end
                    end
                end
                stcs_pkg::ST_STOP: begin
                    if (bit_done) begin
                        state     <= stcs_pkg::ST_IDLE;
                        frame_brk <= 1'b0;
                    end
                end
                stcs_pkg::ST_SYNC: begin
                    if (clock_source_select && tick) begin
                        sclk_o <= !sclk_o;
                    end
                    if (sync_adv) begin
                        if (bit_idx == last_bit) begin
                            state         <= stcs_pkg::ST_IDLE;
                            serial_data_o <= 1'b1;
                        end else begin
                            bit_idx       <= bit_idx + 4'h1;
                            shreg         <= {1'b0, shreg[8:1]};
                            serial_data_o <= shreg[1];
                        end
                    end
                end
                default: begin
                    state <= stcs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_brk_end;
        brk_done && !(wr_ctrl && wb_dat_i[stcs_pkg::BIT_BRK]);
    endsequence

    sequence s_ctrl_read;
        acc_ok && !wb_we_i && (wb_adr_i == stcs_pkg::ADR_CTRL);
    endsequence

    a_master_clk_drive: assert property ((mode_select && clock_source_select) |=> sclk_oe)
        else $error("serial clock not driven in sync master mode");
    a_slave_clk_free: assert property (!(mode_select && clock_source_select) |=> !sclk_oe)
        else $error("serial clock driven while not sync master");
    a_async_no_clk: assert property ((!mode_select && pop)
                                     |=> state == stcs_pkg::ST_START && !sclk_oe)
        else $error("clock select acted in async mode");
    a_frame_last_bit: assert property ((state == stcs_pkg::ST_DATA && bit_done
                                        && bit_idx == last_bit && transmitter_enable)
                                       |=> state == stcs_pkg::ST_STOP && serial_data_o)
        else $error("data phase did not end at last frame bit");
    a_frame_mid_bit: assert property ((state == stcs_pkg::ST_DATA && bit_done
                                       && bit_idx != last_bit && transmitter_enable)
                                      |=> state == stcs_pkg::ST_DATA
                                          && bit_idx == $past(bit_idx) + 4'h1)
        else $error("data phase ended early");
    a_disable_idle: assert property (!transmitter_enable |=> tsr_empty && serial_data_o)
        else $error("shifter active while transmitter disabled");
    a_mode_entry: assert property (pop |=> (state == stcs_pkg::ST_SYNC) == $past(mode_select))
        else $error("frame started in wrong mode");
    a_break_clear: assert property (s_brk_end |=> !break_request && tsr_empty)
        else $error("break request not cleared after break");
    a_sync_no_break: assert property ((pop && mode_select) |=> !frame_brk)
        else $error("break sent in sync mode");
    a_tick_bound: assert property ((state != stcs_pkg::ST_IDLE && !mode_select)
                                   |-> tick_cnt < ticks_per_bit)
        else $error("bit timer ran past selected speed");
    a_empty_read: assert property (s_ctrl_read |=> wb_ack_o
                                   && wb_dat_o[stcs_pkg::BIT_EMPTY] == $past(tsr_empty))
        else $error("empty flag read back wrong");
endmodule // stcs_tx

// ==== stcs_tx_tb.sv ====
/*
 * Self-checking bench for the serial transmit block: register access over
 * classic Wishbone, async frames, break, fifo fill/drain, sync master/slave.
 * Assumes the block at 10 MHz with the peer model on its serial pins.
 */
`timescale 1ns/1ps

module stcs_tx_tb;
    logic        ref_clk  = 1'b0;
    logic        reset    = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        serial_data_o;
    logic        sclk_i;
    logic        sclk_o;
    logic        sclk_oe;
    logic        run      = 1'b0;
    logic        clear    = 1'b0;
    logic [7:0]  cap;
    logic [3:0]  nbits;
    logic [31:0] rd;
    logic [15:0] rv;
    int          num_errors = 0;
    int          cmp_count  = 0;
    int          cycles     = 0;

    always #50 ref_clk = ~ref_clk;

    stcs_tx stcs_tx_inst (
        .ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_data_o(serial_data_o),
        .sclk_i(sclk_i), .sclk_o(sclk_o), .sclk_oe(sclk_oe)
    );

    stcs_peer #(.HALF(8)) stcs_peer_inst (
        .ref_clk(ref_clk), .run(run), .clear(clear), .serial_data_o(serial_data_o),
        .sclk_o(sclk_o), .sclk_oe(sclk_oe), .sclk_i(sclk_i), .cap(cap), .nbits(nbits)
    );

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // whole run needs under 2000 cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one classic cycle; waits for ack however long it takes
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'h3;
        wb_dat_i <= dat;
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0);
        check(what, rd, exp);
    endtask

    // samples mid-bit with margin for a start bit shortened by tick phase
    task automatic rx(input int nb, input int p);
        while (serial_data_o !== 1'b0) @(posedge ref_clk);
        rv = 16'h0000;
        repeat (p + p / 2 - 2) @(posedge ref_clk);
        for (int k = 0; k <= nb; k++) begin
            rv[k] = serial_data_o;
            if (k < nb) repeat (p) @(posedge ref_clk);
        end
    endtask

    initial begin
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        rd_chk("ctrl reset", 8'h00, 32'h02);
        wb(1'b1, 8'h00, 32'h00);
        rd_chk("empty flag after write", 8'h00, 32'h02);
        rd_chk("unmapped", 8'h10, 32'h00);
        wb(1'b1, 8'h08, 32'h01);
        rd_chk("divisor", 8'h08, 32'h01);
        $display("test registers done");

        // transmitter off, clock select set while async
        wb(1'b1, 8'h00, 32'h84);
        for (int i = 0; i < 8; i++) wb(1'b1, 8'h04, 32'h50 + i);
        repeat (20) @(posedge ref_clk);
        check("line held idle", serial_data_o, 32'h1);
        check("no clock drive async", sclk_oe, 32'h0);
        rd_chk("status full", 8'h0c, 32'h18);
        wb(1'b1, 8'h00, 32'ha4);
        rx(8, 8);
        check("first frame", rv, 16'h150);
        repeat (700) @(posedge ref_clk);
        rd_chk("status drained", 8'h0c, 32'h20);
        rd_chk("ctrl idle", 8'h00, 32'ha6);
        $display("test fifo done");

        wb(1'b1, 8'h00, 32'h65);
        wb(1'b1, 8'h04, 32'ha3);
        rx(9, 8);
        check("nine bit frame", rv, 16'h3a3);
        repeat (10) @(posedge ref_clk);
        wb(1'b1, 8'h00, 32'h20);
        wb(1'b1, 8'h04, 32'h96);
        rx(8, 32);
        check("low speed frame", rv, 16'h196);
        $display("test async frames done");

        repeat (40) @(posedge ref_clk);
        wb(1'b1, 8'h00, 32'h2c);
        rd_chk("break pending", 8'h00, 32'h2e);
        wb(1'b1, 8'h04, 32'hff);
        rx(12, 8);
        check("break frame", rv, 16'h1000);
        repeat (20) @(posedge ref_clk);
        rd_chk("break done", 8'h00, 32'h26);
        $display("test break done");

        clear <= 1'b1;
        wb(1'b1, 8'h00, 32'hb0);
        clear <= 1'b0;
        wb(1'b1, 8'h04, 32'h3c);
        check("master drives clock", sclk_oe, 32'h1);
        while (nbits < 4'h2) @(posedge ref_clk);
        rd_chk("shifting", 8'h00, 32'hb0);
        wb(1'b1, 8'h00, 32'hb2);
        rd_chk("empty flag held low", 8'h00, 32'hb0);
        while (nbits < 4'h8) @(posedge ref_clk);
        repeat (20) @(posedge ref_clk);
        rd_chk("sync done", 8'h00, 32'hb2);
        check("sync master data", cap, 32'h3c);
        $display("test sync master done");

        clear <= 1'b1;
        wb(1'b1, 8'h00, 32'h30);
        clear <= 1'b0;
        wb(1'b1, 8'h04, 32'ha6);
        check("slave leaves clock", sclk_oe, 32'h0);
        run <= 1'b1;
        while (nbits < 4'h8) @(posedge ref_clk);
        run <= 1'b0;
        repeat (20) @(posedge ref_clk);
        check("sync slave data", cap, 32'ha6);
        $display("test sync slave done");
        end_of_test();
    end
endmodule // stcs_tx_tb
